// ---- change_irq_pkg.sv ----
// package for the pin edge change interrupt block: register map, field layouts, reset values.
// assumes a 32-bit apb slave with one register per aligned word.
package change_irq_pkg;

  localparam int PORT_WIDTH = 8;
  localparam int ADDR_WIDTH = 12;

  // register byte offsets
  localparam logic [11:0] OFF_PORT_A_RISE = 12'h000;
  localparam logic [11:0] OFF_PORT_A_FALL = 12'h004;
  localparam logic [11:0] OFF_PORT_A_FLAGS = 12'h008;
  localparam logic [11:0] OFF_PORT_B_RISE = 12'h00C;
  localparam logic [11:0] OFF_PORT_B_FALL = 12'h010;
  localparam logic [11:0] OFF_PORT_B_FLAGS = 12'h014;
  localparam logic [11:0] OFF_PORT_C_RISE = 12'h018;
  localparam logic [11:0] OFF_PORT_C_FALL = 12'h01C;
  localparam logic [11:0] OFF_PORT_C_FLAGS = 12'h020;
  localparam logic [11:0] OFF_CONTROL = 12'h024;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h028;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h02C;

  // control register fields
  localparam int CTRL_MASTER_ENABLE_BIT = 0;
  localparam int CTRL_GLOBAL_FLAG_BIT = 1;

  // event status / mask layout
  localparam int EVT_COUNT = 3;
  localparam int EVT_PORT_A_BIT = 0;
  localparam int EVT_PORT_B_BIT = 1;
  localparam int EVT_PORT_C_BIT = 2;

  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [2:0] EVT_RESET = 3'h0;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] rise;
    logic [7:0] fall;
    logic [7:0] flags;
  } port_regs_t;

  typedef struct packed {
    logic [11:0] addr;
    logic sel;
    logic enable;
    logic write;
    logic [31:0] wdata;
  } apb_req_t;

endpackage : change_irq_pkg

// ---- pin_edge_change_interrupt.sv ----
// pin edge change interrupt block for ports a, b and c, with an apb register slave.
// assumes pins are asynchronous to pclk and that sleep/wake sequencing lives in the core.
// register map, one aligned 32-bit word per register, upper bits read 0:
//   0x000 port a rise enable    0x004 port a fall enable    0x008 port a flags
//   0x00c port b rise enable    0x010 port b fall enable    0x014 port b flags
//   0x018 port c rise enable    0x01c port c fall enable    0x020 port c flags
//   0x024 control: bit 0 master enable, bit 1 global flag (read only)
//   0x028 event status: one sticky bit per port, cleared by reading it
//   0x02c event mask: same layout as event status
//
// latency, in pclk edges after a pin settles:
//   edge 1 first sync stage, edge 2 second sync stage
//   edge 3 per-pin flag, event status, change_irq and change_wake set
//   edge 4 event_irq follows
//   a pin pulse shorter than one pclk period may be missed
//
// bus side: zero wait states; only byte lane 0 writes, other lanes ignored;
// an unmapped access answers with pslverr, reads 0 and writes nothing.
//
// pins: three 8-bit ports, asynchronous to pclk; bit i of every port
// register belongs to pin i of that port.
//
// sleep: pclk keeps running through sleep, so an edge is flagged and the
// wake level raised before the core can fetch its first instruction;
// gating pclk in sleep would lose edges and is not supported.
//
// limits: no glitch filter, so a noisy pin can set its flag on a spike
// that lasts one pclk period; debounce belongs outside this block if the
// pins are mechanical contacts.
`timescale 1ns/1ps

module pin_edge_change_interrupt
  import change_irq_pkg::*;
#(
  parameter int NUM_PORTS = 3
) (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // port pins, asynchronous
  input wire logic [PORT_WIDTH-1:0] port_a_pin,
  input wire logic [PORT_WIDTH-1:0] port_b_pin,
  input wire logic [PORT_WIDTH-1:0] port_c_pin,
  // interrupt and wake
  output logic change_irq,
  output logic change_wake,
  output logic event_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  apb_req_t req;
  logic wr_en;
  logic rd_en;
  logic addr_hit;

  assign req = '{addr: paddr, sel: psel, enable: penable, write: pwrite, wdata: pwdata};
  // the request is taken only in the access phase; pready is tied high,
  // so every access phase is exactly one cycle long
  assign wr_en = req.sel && req.enable && req.write;
  assign rd_en = req.sel && req.enable && !req.write;
  // zero wait states; byte lane 0 carries all the 8-bit fields
  assign pready = 1'b1;

  // one hit decoder for the whole map; unaligned or unknown addresses miss
  always_comb begin
    case (req.addr)
      OFF_PORT_A_RISE, OFF_PORT_A_FALL, OFF_PORT_A_FLAGS,
      OFF_PORT_B_RISE, OFF_PORT_B_FALL, OFF_PORT_B_FLAGS,
      OFF_PORT_C_RISE, OFF_PORT_C_FALL, OFF_PORT_C_FLAGS,
      OFF_CONTROL, OFF_IRQ_STATUS, OFF_IRQ_MASK: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  // error is combinational so it stands with the access phase it answers
  assign pslverr = req.sel && req.enable && !addr_hit;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detect

  logic [NUM_PORTS*PORT_WIDTH-1:0] pins_raw;
  logic [NUM_PORTS*PORT_WIDTH-1:0] pins_meta;
  logic [NUM_PORTS*PORT_WIDTH-1:0] pins_sync;
  logic [NUM_PORTS*PORT_WIDTH-1:0] pins_prev;
  logic [NUM_PORTS*PORT_WIDTH-1:0] rise_seen;
  logic [NUM_PORTS*PORT_WIDTH-1:0] fall_seen;

  // each pin passes two flops before any logic reads it; both stages reset
  // to 0, so a pin held high across reset shows up as a rising edge about
  // three edges after release, flagged only if enabled by then
  // port c sits in the top byte, port a in the bottom byte
  assign pins_raw = {port_c_pin, port_b_pin, port_a_pin};

  // meta stage is read only by the sync stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_meta <= '0;
      pins_sync <= '0;
    end else begin
      pins_meta <= pins_raw;
      pins_sync <= pins_meta;
    end
  end

  // prev is loaded from sync, so a pin held high across reset gives an edge only after
  // the first two samples; the same way an edge in sleep is caught while pclk runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_prev <= '0;
    end else begin
      pins_prev <= pins_sync;
    end
  end

  // one-cycle pulses; a pin that toggles twice between samples is lost,
  // which is the price of sampling instead of using the pin as a clock
  assign rise_seen = pins_sync & ~pins_prev;
  assign fall_seen = ~pins_sync & pins_prev;

  ////////////////////////////////////////////////////////////////////////////
  // per-port registers
  // one generate instance per port; every port has the same three registers,
  // so ports differ only in their offsets and pin slice

  port_regs_t regs [NUM_PORTS];
  logic [NUM_PORTS-1:0] port_hit_any;
  logic [PORT_WIDTH-1:0] port_detect [NUM_PORTS];
  logic [NUM_PORTS*PORT_WIDTH-1:0] detect_all;

  localparam logic [11:0] RISE_OFF [3] = '{OFF_PORT_A_RISE, OFF_PORT_B_RISE, OFF_PORT_C_RISE};
  localparam logic [11:0] FALL_OFF [3] = '{OFF_PORT_A_FALL, OFF_PORT_B_FALL, OFF_PORT_C_FALL};
  localparam logic [11:0] FLAG_OFF [3] = '{OFF_PORT_A_FLAGS, OFF_PORT_B_FLAGS, OFF_PORT_C_FLAGS};
  // the offset tables hold three ports; a wider build must extend them

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_port
      logic [PORT_WIDTH-1:0] next_flags;
      logic wr_low;
      logic rise_wr;
      logic fall_wr;
      logic flag_wr;

      assign wr_low = wr_en && pstrb[0];
      assign rise_wr = wr_low && req.addr == RISE_OFF[p];
      assign fall_wr = wr_low && req.addr == FALL_OFF[p];
      assign flag_wr = wr_low && req.addr == FLAG_OFF[p];
      assign detect_all[p*PORT_WIDTH +: PORT_WIDTH] = port_detect[p];

      // either enable may be set alone or together
      assign port_detect[p] =
        (rise_seen[p*PORT_WIDTH +: PORT_WIDTH] & regs[p].rise) |
        (fall_seen[p*PORT_WIDTH +: PORT_WIDTH] & regs[p].fall);
      assign port_hit_any[p] = |port_detect[p];

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          regs[p].rise <= PORT_RESET;
        end else if (rise_wr) begin
          regs[p].rise <= req.wdata[PORT_WIDTH-1:0];
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          regs[p].fall <= PORT_RESET;
        end else if (fall_wr) begin
          regs[p].fall <= req.wdata[PORT_WIDTH-1:0];
        end
      end

      // a write can only clear: writing 1 keeps the bit, and a new edge wins
      // software should clear by writing the inverse of the bits it has handled, so a
      // flag that set after its last read is not wiped by a blind write of 0
      always_comb begin
        next_flags = regs[p].flags;
        if (flag_wr) begin
          next_flags = regs[p].flags & req.wdata[PORT_WIDTH-1:0];
        end
        next_flags = next_flags | port_detect[p];
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          regs[p].flags <= PORT_RESET;
        end else begin
          regs[p].flags <= next_flags;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // global flag, master enable, interrupt

  logic master_enable;
  logic global_flag;
  logic [NUM_PORTS*PORT_WIDTH-1:0] all_flags;

  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      all_flags[i*PORT_WIDTH +: PORT_WIDTH] = regs[i].flags;
    end
  end

  // global flag is not stored: it is the or of the flag registers, so it
  // can never disagree with them
  // read-only: it clears only when every per-pin flag is cleared
  assign global_flag = |all_flags;

  // master enable gates only the request; flags and status ignore it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_enable <= 1'b0;
    end else if (wr_en && pstrb[0] && req.addr == OFF_CONTROL) begin
      master_enable <= req.wdata[CTRL_MASTER_ENABLE_BIT];
    end
  end

  // the flag still sets with the master off; only the request is gated
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      change_irq <= 1'b0;
    end else begin
      // detect is ored in so the request does not wait for the flag to land
      change_irq <= master_enable && (|(all_flags | detect_all));
    end
  end

  // wake is a level that the core's sleep controller samples
  assign change_wake = change_irq;

  ////////////////////////////////////////////////////////////////////////////
  // event status and mask: sticky per-port events, cleared by reading status
  // the status register is a coarser view: which ports saw an enabled edge
  // since status was last read; the per-pin flags keep the detail
  // event_irq ignores the master enable, it serves this per-port view only

  logic [EVT_COUNT-1:0] evt_status;
  logic [EVT_COUNT-1:0] evt_mask;
  logic status_read;

  assign status_read = rd_en && req.addr == OFF_IRQ_STATUS;

  // a new event in the read cycle survives the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_status <= EVT_RESET;
    end else begin
      evt_status <= (status_read ? EVT_RESET : evt_status) | port_hit_any;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_mask <= EVT_RESET;
    end else if (wr_en && pstrb[0] && req.addr == OFF_IRQ_MASK) begin
      evt_mask <= req.wdata[EVT_COUNT-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_irq <= 1'b0;
    end else begin
      event_irq <= |(evt_status & evt_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux, registered as a data output
  // the mux is decoded from the setup cycle address; a write setup does not
  // disturb prdata, so read data stays put until the next read

  logic [31:0] next_prdata;

  always_comb begin
    next_prdata = READ_ZERO;
    case (req.addr)
      OFF_PORT_A_RISE: next_prdata[PORT_WIDTH-1:0] = regs[0].rise;
      OFF_PORT_A_FALL: next_prdata[PORT_WIDTH-1:0] = regs[0].fall;
      OFF_PORT_A_FLAGS: next_prdata[PORT_WIDTH-1:0] = regs[0].flags;
      OFF_PORT_B_RISE: next_prdata[PORT_WIDTH-1:0] = regs[1].rise;
      OFF_PORT_B_FALL: next_prdata[PORT_WIDTH-1:0] = regs[1].fall;
      OFF_PORT_B_FLAGS: next_prdata[PORT_WIDTH-1:0] = regs[1].flags;
      OFF_PORT_C_RISE: next_prdata[PORT_WIDTH-1:0] = regs[2].rise;
      OFF_PORT_C_FALL: next_prdata[PORT_WIDTH-1:0] = regs[2].fall;
      OFF_PORT_C_FLAGS: next_prdata[PORT_WIDTH-1:0] = regs[2].flags;
      OFF_CONTROL: begin
        next_prdata[CTRL_MASTER_ENABLE_BIT] = master_enable;
        next_prdata[CTRL_GLOBAL_FLAG_BIT] = global_flag;
      end
      OFF_IRQ_STATUS: next_prdata[EVT_COUNT-1:0] = evt_status;
      OFF_IRQ_MASK: next_prdata[EVT_COUNT-1:0] = evt_mask;
      default: next_prdata = READ_ZERO;
    endcase
  end

  // prdata is loaded in the setup cycle so it is stable in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= READ_ZERO;
    end else if (req.sel && !req.enable && !req.write) begin
      prdata <= next_prdata;
    end
  end

endmodule : pin_edge_change_interrupt

// ---- change_irq_chk.sv ----
// checker for the change interrupt block, bound to its top module.
// assumes one domain: pclk, with presetn as async active-low reset.
`timescale 1ns/1ps
module change_irq_chk
  import change_irq_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // interrupt outputs
  input wire logic change_irq,
  input wire logic change_wake
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic men;
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  // shadow of the master enable, tracked from bus writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      men <= 1'b0;
    end else if (wr && pstrb[0] && paddr == OFF_CONTROL) begin
      men <= pwdata[0];
    end
  end
  ////////////////////////////////////////////////////////////////
  a_wake_matches: assert property (change_wake == change_irq)
    else $error("wake differs from irq");
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_unmapped: assert property (acc && paddr > OFF_IRQ_MASK |-> pslverr)
    else $error("no error on unmapped access");
  a_err_mapped: assert property (acc && paddr <= OFF_IRQ_MASK && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("error on mapped access");
  a_irq_masked: assert property (change_irq |-> $past(men))
    else $error("irq with master enable off");
  a_irq_holds: assert property (!wr ##1 (change_irq && !wr) |=> change_irq)
    else $error("irq dropped without a write");
  a_rdata_stable: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved outside a read");
  a_unmapped_zero: assert property (acc && !pwrite && pslverr |-> prdata == READ_ZERO)
    else $error("unmapped read not zero");
  c_ctrl_write: cover property (wr && paddr == OFF_CONTROL);
  c_irq_rise: cover property ($rose(change_irq));
  c_slverr: cover property (pslverr);
endmodule : change_irq_chk

bind pin_edge_change_interrupt change_irq_chk chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .change_irq, .change_wake);

// ---- pin_source.sv ----
// external pin model for ports a, b and c.
// assumes the bench posts target levels on want at rising edges.
`timescale 1ns/1ps
module pin_source (
  // clock and target levels
  input wire logic pclk,
  input wire logic [23:0] want,
  // pins
  output logic [7:0] port_a_pin,
  output logic [7:0] port_b_pin,
  output logic [7:0] port_c_pin
);
  // pins move on the falling edge, unrelated to the sampling edge
  always @(negedge pclk) begin
    {port_c_pin, port_b_pin, port_a_pin} <= want;
  end
endmodule : pin_source

// ---- test_pin_edge_change_interrupt.sv ----
// self-checking bench: random edges and enables with corner cases.
// assumes the checker is bound and pin_source drives the pins.
`timescale 1ns/1ps
module test_pin_edge_change_interrupt;
  import change_irq_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr, men;
  logic change_irq, change_wake, event_irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [23:0] want;
  logic [7:0] pa, pb, pc, tmp, r [3], f [3], old [3], nw [3], ex [3];
  logic [15:0] seed;
  logic [2:0] mask, evt;
  int err_count, tests_run;

  pin_edge_change_interrupt DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .port_a_pin(pa), .port_b_pin(pb),
    .port_c_pin(pc), .change_irq, .change_wake, .event_irq);
  pin_source pins (.pclk, .want, .port_a_pin(pa), .port_b_pin(pb), .port_c_pin(pc));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] next8();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction : next8

  function automatic logic [7:0] exp_flags(logic [7:0] r, f, o, n);
    return (r & ~o & n) | (f & o & ~n);
  endfunction : exp_flags

  task final_report;
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // entered right after a rising edge; returns after one idle edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) begin
      err_count++;
      final_report();
    end
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  ////////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, want, err_count, tests_run} = '0;
    pstrb = 4'hf;
    seed = 16'h8d81;
    old = '{3{8'h00}};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a < 13; a++) begin
      apb(1'b0, 12'(4 * a), '0);
      chk(rd, '0);
      chk({31'h0, perr}, {31'h0, a == 12});
    end
    for (int it = 0; it < 12; it++) begin
      tmp = next8();
      men = tmp[0];
      mask = tmp[3:1];
      apb(1'b1, OFF_CONTROL, {31'h0, men});
      apb(1'b1, OFF_IRQ_MASK, {29'h0, mask});
      for (int p = 0; p < 3; p++) begin
        r[p] = next8();
        f[p] = next8();
        nw[p] = next8();
        // first pass arms both edges everywhere, second disarms all
        if (it < 2) begin
          r[p] = {8{it == 0}};
          f[p] = r[p];
        end
        apb(1'b1, 12'(12 * p), {24'h0, r[p]});
        apb(1'b1, 12'(12 * p + 4), {24'h0, f[p]});
        apb(1'b0, 12'(12 * p), '0);
        chk(rd, {24'h0, r[p]});
        apb(1'b0, 12'(12 * p + 4), '0);
        chk(rd, {24'h0, f[p]});
        ex[p] = exp_flags(r[p], f[p], old[p], nw[p]);
      end
      want <= {nw[2], nw[1], nw[0]};
      repeat (6) @(posedge pclk);
      evt = {|ex[2], |ex[1], |ex[0]};
      chk({31'h0, change_irq}, {31'h0, men & |evt});
      chk({31'h0, event_irq}, {31'h0, |(evt & mask)});
      apb(1'b0, OFF_CONTROL, '0);
      chk(rd, {30'h0, |evt, men});
      apb(1'b0, OFF_IRQ_STATUS, '0);
      chk(rd, {29'h0, evt});
      for (int p = 0; p < 3; p++) begin
        apb(1'b0, 12'(12 * p + 8), '0);
        chk(rd, {24'h0, ex[p]});
        apb(1'b1, 12'(12 * p + 8), '0);
        apb(1'b0, 12'(12 * p + 8), '0);
        chk(rd, '0);
        old[p] = nw[p];
      end
      chk({31'h0, change_irq}, '0);
    end
    // port a toggles so its flags set in the very cycle a write of 0 lands
    apb(1'b1, OFF_PORT_A_RISE, 32'h0000_00ff);
    apb(1'b1, OFF_PORT_A_FALL, 32'h0000_00ff);
    want <= {nw[2], nw[1], ~old[0]};
    @(posedge pclk);
    apb(1'b1, OFF_PORT_A_FLAGS, '0);
    apb(1'b0, OFF_PORT_A_FLAGS, '0);
    chk(rd, 32'h0000_00ff);
    // second reset in mid-run: every register must read 0 again
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a < 12; a++) begin
      apb(1'b0, 12'(4 * a), '0);
      chk(rd, '0);
    end
    final_report();
  end
endmodule : test_pin_edge_change_interrupt
